/* pst_pkg.sv */
// Package: command codes, status bit layout, timing counts for the status/telemetry block
// Summary of operation
// [RULE_01] Supported status bits clear by clear-faults or write-1; code clears only latched bits 7, 3, 2, 1, live bit 6 is not cleared
// [RULE_02] Bit 7 latches on power-on check failure
// [RULE_03] Bit 6 live: self-check busy or slaves missing
// [RULE_04] Bits 5:4 and 0 read zero always
// [RULE_05] Bit 3 latches on output-voltage reset event
// [RULE_06] Bit 2 latches on back-channel link fault
// [RULE_07] Bit 1 latches on sync fault
// [RULE_08] Each alerting bit has its own mask bit
// [RULE_09] Input voltage word refreshed every 1 ms
// [RULE_10] Phase all-ones returns stack master input voltage
// [RULE_11] Other phase returns selected device input voltage
// [RULE_12] Output voltage word refreshed every 1 ms
// [RULE_13] Stack slave reports raw sense-pin voltage
// [RULE_14] Telemetry write flags comm fault and alerts
// [RULE_15] Latched bits hold until explicit clear
package pst_pkg;
   // Command codes
   localparam logic [7:0] PST_CMD_VENDOR_STATUS = 8'h80;
   localparam logic [7:0] PST_CMD_VIN = 8'h88;
   localparam logic [7:0] PST_CMD_VOUT = 8'h8B;
   // Status byte bit positions
   localparam int PST_BIT_POR = 7;
   localparam int PST_BIT_SELF = 6;
   localparam int PST_BIT_RESET = 3;
   localparam int PST_BIT_BCL = 2;
   localparam int PST_BIT_SYNC = 1;
   // Latched, writable-one-to-clear bits
   localparam logic [7:0] PST_LATCH_MASK = 8'h8E;
   localparam logic [7:0] PST_STATUS_RST = 8'h00;
   localparam logic [7:0] PST_MASK_RST = 8'h00;
   localparam logic [7:0] PST_PHASE_ALL = 8'hFF;
   // Invalid-command bit in the comms status byte
   localparam int PST_BIT_IVC = 7;
   // Telemetry refresh period
   localparam int PST_CLK_MHZ = 100;
   localparam int PST_REFRESH_US = 1000;
   localparam int PST_REFRESH_CYC = PST_REFRESH_US * PST_CLK_MHZ;
   localparam logic [16:0] PST_REFRESH_LAST = 17'(PST_REFRESH_CYC - 1);
endpackage

/* pst_tick.sv */
// Refresh-period divider producing a one-cycle tick
`timescale 1ns/10ps
module pst_tick
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [16:0] last,
   output logic tick
);
   import pst_pkg::*;
   logic [16:0] cnt_r;
   logic [16:0] cnt_nxt;
   logic tick_nxt;
   // Count up and wrap at the last cycle of the period
   always_comb
   begin
      tick_nxt = (cnt_r == last);
      cnt_nxt = tick_nxt ? 17'h00000 : cnt_r + 17'h00001;
   end
   // Register
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= 17'h00000;
         tick <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick <= tick_nxt;
      end
   end
endmodule

/* pst_status_telemetry.sv */
// Vendor fault status byte, phase-selectable input voltage word and output voltage word
`timescale 1ns/10ps
module pst_status_telemetry
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cmd_wr,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_wdata,
   input wire logic clear_faults,
   input wire logic [7:0] alert_mask,
   input wire logic [7:0] phase_sel,
   input wire logic por_check_bad,
   input wire logic self_check_busy,
   input wire logic slaves_pending,
   input wire logic vout_reset_evt,
   input wire logic back_channel_link_fault,
   input wire logic sync_fault,
   input wire logic is_stack_master,
   input wire logic slave_mode,
   input wire logic [15:0] master_vin,
   input wire logic [15:0] phase_vin,
   input wire logic [15:0] vout_scaled,
   input wire logic [15:0] output_sense_pin_raw,
   output logic [7:0] vendor_fault_status,
   output logic [15:0] input_voltage_reading,
   output logic [15:0] output_voltage_reading,
   output logic cml_fault,
   output logic cml_ivc,
   output logic alert_req
);
   import pst_pkg::*;
   // Next-state values and internal strobes
   logic [7:0] latch_r; // Latched fault bits
   logic [7:0] latch_nxt; // Latches after set and clear
   logic [7:0] status_nxt; // Latches plus live bit
   logic [15:0] vin_nxt; // Next input voltage word
   logic [15:0] vout_nxt; // Next output voltage word
   logic ivc_nxt; // Next invalid-command flag
   logic alert_nxt; // Next alert request
   logic tick; // Refresh strobe
   logic wr_ro; // Write to a telemetry command

   // Refresh divider
   pst_tick u_tick
   (
      .mclk(mclk),
      .resetn(resetn),
      .last(PST_REFRESH_LAST),
      .tick(tick)
   );

   // Helper: is code a read-only telemetry command
   function automatic logic is_ro(input logic [7:0] c);
      is_ro = (c == PST_CMD_VIN) || (c == PST_CMD_VOUT);
   endfunction

   // Writes to read-only words are refused but flagged
   assign wr_ro = cmd_wr && is_ro(cmd_code);

   // Latched fault set/clear, set wins over clear
   always_comb
   begin
      // Default: every latched bit holds
      latch_nxt = latch_r;
      // Clears go first so that an event in the same cycle wins
      // [RULE_01] clear-faults and write-1
      if (clear_faults)
         latch_nxt = PST_STATUS_RST;
      else if (cmd_wr && cmd_code == PST_CMD_VENDOR_STATUS)
         latch_nxt = latch_r & ~(cmd_wdata & PST_LATCH_MASK);
      // [RULE_02] power-on check latch
      if (por_check_bad)
         latch_nxt[PST_BIT_POR] = 1'b1;
      // [RULE_05] output reset latch
      if (vout_reset_evt)
         latch_nxt[PST_BIT_RESET] = 1'b1;
      // [RULE_06] back-channel fault latch
      if (back_channel_link_fault)
         latch_nxt[PST_BIT_BCL] = 1'b1;
      // [RULE_07] sync fault latch
      if (sync_fault)
         latch_nxt[PST_BIT_SYNC] = 1'b1;
      // [RULE_04] unsupported bits forced zero
      latch_nxt = latch_nxt & PST_LATCH_MASK;
      // Live bit built from the inputs, never latched
      // [RULE_03] live self-check bit
      status_nxt = latch_nxt;
      status_nxt[PST_BIT_SELF] = self_check_busy || slaves_pending;
   end

   // Telemetry and comms-fault next values
   always_comb
   begin
      vin_nxt = input_voltage_reading;
      vout_nxt = output_voltage_reading;
      if (tick)
      begin
         // [RULE_10] all-ones phase picks master
         if (phase_sel == PST_PHASE_ALL)
            vin_nxt = master_vin;
         // [RULE_11] selected phase device
         else
            vin_nxt = phase_vin;
         // [RULE_13] slave reports raw sense pin
         if (slave_mode && !is_stack_master)
            vout_nxt = output_sense_pin_raw;
         // [RULE_12] scaled output reading
         else
            vout_nxt = vout_scaled;
      end
      // A write in the clearing cycle still flags, like the status bits
      // [RULE_14] invalid command latch
      ivc_nxt = clear_faults ? 1'b0 : cml_ivc;
      if (wr_ro)
         ivc_nxt = 1'b1;
      // Uses next-cycle latches so alert lines up with the status byte
      // [RULE_08] per-bit alert masking
      alert_nxt = |(latch_nxt & ~alert_mask) || ivc_nxt;
   end

   // Registers; telemetry only moves on the refresh tick
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         // Reading words stay zero until the first tick
         latch_r <= PST_STATUS_RST;
         vendor_fault_status <= PST_STATUS_RST;
         input_voltage_reading <= 16'h0000;
         output_voltage_reading <= 16'h0000;
         cml_ivc <= 1'b0;
         cml_fault <= 1'b0;
         alert_req <= 1'b0;
      end
      else
      begin
         // [RULE_15] hold until cleared
         latch_r <= latch_nxt;
         vendor_fault_status <= status_nxt;
         // [RULE_09] refresh every period
         input_voltage_reading <= vin_nxt;
         output_voltage_reading <= vout_nxt;
         cml_ivc <= ivc_nxt;
         cml_fault <= ivc_nxt;
         alert_req <= alert_nxt;
      end
   end

   // Telemetry write raises comm fault next cycle
   AST_RO_WRITE: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_14]
      wr_ro |=> cml_ivc && cml_fault && alert_req)
      else $error("telemetry write not flagged");
   // Sync event latches and shows
   AST_SYNC_LATCH: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_07]
      sync_fault |=> vendor_fault_status[PST_BIT_SYNC])
      else $error("sync fault not latched");
   AST_BCL_LATCH: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_06]
      back_channel_link_fault |=> vendor_fault_status[PST_BIT_BCL])
      else $error("link fault not latched");
   AST_RST_LATCH: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_05]
      vout_reset_evt |=> vendor_fault_status[PST_BIT_RESET])
      else $error("reset event not latched");
   AST_POR_LATCH: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_02]
      por_check_bad |=> vendor_fault_status[PST_BIT_POR])
      else $error("power-on fault not latched");
   AST_UNSUP_ZERO: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_04]
      vendor_fault_status[5:4] == 2'b00 && !vendor_fault_status[0])
      else $error("unsupported bit set");
   AST_SELF_LIVE: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_03]
      ##1 vendor_fault_status[PST_BIT_SELF] == $past(self_check_busy || slaves_pending))
      else $error("self-check bit wrong");
   AST_CLEAR: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_01]
      clear_faults && !sync_fault |=> !vendor_fault_status[PST_BIT_SYNC])
      else $error("clear-faults ignored");
   AST_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_15]
      latch_r[PST_BIT_SYNC] && !clear_faults && !cmd_wr |=> latch_r[PST_BIT_SYNC])
      else $error("latched bit dropped");
   AST_VIN_MASTER: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_10]
      tick && phase_sel == PST_PHASE_ALL |=> input_voltage_reading == $past(master_vin))
      else $error("master vin not selected");
   AST_VIN_PHASE: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_11]
      tick && phase_sel != PST_PHASE_ALL |=> input_voltage_reading == $past(phase_vin))
      else $error("phase vin not selected");
   AST_VIN_STABLE: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_09]
      !tick |=> $stable(input_voltage_reading))
      else $error("vin moved off tick");
   AST_VOUT_SLAVE: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_13]
      tick && slave_mode && !is_stack_master |=>
      output_voltage_reading == $past(output_sense_pin_raw))
      else $error("slave vout not raw");
   AST_VOUT_STABLE: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_12]
      !tick |=> $stable(output_voltage_reading))
      else $error("vout moved off tick");
   AST_MASK: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_08]
      (alert_mask == 8'hFF) && !ivc_nxt |=> !alert_req)
      else $error("masked alert raised");
   // Alert follows an unmasked latched link fault
   AST_ALERT_BCL: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_08]
      vendor_fault_status[PST_BIT_BCL] && !$past(alert_mask[PST_BIT_BCL]) |-> alert_req)
      else $error("unmasked fault gave no alert");
   // Write of one clears a latched bit when no event repeats
   AST_W1C: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_01]
      cmd_wr && cmd_code == PST_CMD_VENDOR_STATUS && cmd_wdata[PST_BIT_SYNC] && !sync_fault
      |=> !vendor_fault_status[PST_BIT_SYNC])
      else $error("write-one clear ignored");
   // Master or non-slave reporting takes the scaled reading
   AST_VOUT_SCALED: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_12]
      tick && !(slave_mode && !is_stack_master) |=>
      output_voltage_reading == $past(vout_scaled))
      else $error("scaled vout not selected");
   // Telemetry write, then the flag stands next cycle
   sequence ro_write_flagged;
      wr_ro ##1 cml_ivc;
   endsequence
   // Flag still stands a second cycle after a telemetry write when clear-faults is low
   AST_IVC_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_14]
      ro_write_flagged ##0 !clear_faults |=> cml_ivc)
      else $error("comm fault flag dropped");
   // Clear-faults with no new telemetry write drops the flag
   AST_IVC_CLEAR: assert property (@(posedge mclk) disable iff (!resetn) // [RULE_14]
      clear_faults && !wr_ro |=> !cml_ivc && !cml_fault)
      else $error("comm fault not cleared");
endmodule

/* pst_host.sv */
// PMBus host model: command strobes and read-back of command data
`timescale 1ns/10ps
module pst_host
(
   input wire logic mclk,
   output logic cmd_wr,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_wdata,
   output logic clear_faults,
   input wire logic [7:0] vendor_fault_status,
   input wire logic [15:0] input_voltage_reading,
   input wire logic [15:0] output_voltage_reading,
   output logic rsp_v,
   output logic [15:0] rsp_data
);
   // Idle bus at time zero
   initial
   begin
      cmd_wr = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 8'h00;
      clear_faults = 1'b0;
      rsp_v = 1'b0;
      rsp_data = 16'h0000;
   end
   task automatic wr(input logic [7:0] code, input logic [7:0] data);
   begin
      cmd_wr = 1'b1;
      cmd_code = code;
      cmd_wdata = data;
      @(posedge mclk);
      #1;
      cmd_wr = 1'b0;
      // Released lines show inverse so stale data cannot pass
      cmd_code = ~code;
      cmd_wdata = ~data;
   end
   endtask
   task automatic clr();
   begin
      clear_faults = 1'b1;
      @(posedge mclk);
      #1;
      clear_faults = 1'b0;
   end
   endtask
   // Read: capture the addressed word, flag it for one edge
   task automatic rd(input logic [7:0] code);
   begin
      @(posedge mclk);
      #1;
      rsp_data = (code == 8'h80) ? {8'h00, vendor_fault_status} :
                 (code == 8'h88) ? input_voltage_reading : output_voltage_reading;
      rsp_v = 1'b1;
      @(posedge mclk);
      #1;
      rsp_v = 1'b0;
      rsp_data = ~rsp_data;
   end
   endtask
endmodule

/* tb_top.sv */
// Testbench for the vendor status byte and telemetry words
`timescale 1ns/10ps
module tb_top;
   import pst_pkg::*;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_wr, clear_faults, rsp_v;
   logic [7:0] cmd_code, cmd_wdata, vfs;
   logic [7:0] alert_mask = 8'h00;
   logic [7:0] phase_sel = 8'hFF;
   logic [3:0] ev = 4'h0; // por, reset, link, sync events
   logic busy = 1'b0;
   logic pend = 1'b0;
   logic slave_mode = 1'b1;
   logic master = 1'b0; // Stack master strap, low so slave reporting applies
   logic [15:0] mvin, power_input_rail, vsc, raw, vin_rd, vout_rd, rsp_data;
   logic cml_fault, cml_ivc, alert_req;
   logic [15:0] exp_q[$]; // Expected read results, oldest first
   int checks = 0;
   int miscompares = 0;
   int seed = 32'hcd5a;
   int pos[4] = '{7, 3, 2, 1};
   always #5 mclk = ~mclk;
   pst_status_telemetry dut_u (.mclk(mclk), .resetn(resetn), .cmd_wr(cmd_wr),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
      .alert_mask(alert_mask), .phase_sel(phase_sel), .por_check_bad(ev[3]),
      .self_check_busy(busy), .slaves_pending(pend), .vout_reset_evt(ev[2]),
      .back_channel_link_fault(ev[1]), .sync_fault(ev[0]), .is_stack_master(master),
      .slave_mode(slave_mode), .master_vin(mvin), .phase_vin(power_input_rail), .vout_scaled(vsc),
      .output_sense_pin_raw(raw), .vendor_fault_status(vfs),
      .input_voltage_reading(vin_rd), .output_voltage_reading(vout_rd),
      .cml_fault(cml_fault), .cml_ivc(cml_ivc), .alert_req(alert_req));
   pst_host host_u (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .clear_faults(clear_faults), .vendor_fault_status(vfs),
      .input_voltage_reading(vin_rd), .output_voltage_reading(vout_rd),
      .rsp_v(rsp_v), .rsp_data(rsp_data));
   // Verdict; the single place the run ends
   task automatic complete_run();
   begin
      // Notes never matched by a read count together as one mismatch
      if (exp_q.size() != 0)
         miscompares++;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   // Direct comparison of a design flag
   task automatic chk(input logic got, input logic want);
   begin
      checks++;
      if (got !== want)
      begin
         miscompares++;
         $display("unexpected at %0t: flag %b want %b", $time, got, want);
      end
   end
   endtask
   // Note the expectation, then let the host read
   task automatic rd(input logic [7:0] code, input logic [15:0] want);
   begin
      exp_q.push_back(want);
      host_u.rd(code);
   end
   endtask
   // Monitor: oldest note against each read result
   always @(posedge mclk)
   begin
      if (rsp_v === 1'b1)
      begin
         checks++;
         if (exp_q.size() == 0 || rsp_data !== exp_q[0])
         begin
            miscompares++;
            $display("unexpected at %0t: read %h", $time, rsp_data);
         end
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
   end
   // Main sequence
   initial
   begin
      mvin = 16'(($random(seed) & 32'hFFFE) | 1);
      power_input_rail = 16'($random(seed));
      vsc = 16'($random(seed));
      raw = ~vsc;
      repeat (20) @(posedge mclk);
      #1;
      resetn = 1'b1;
      rd(8'h80, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         ev = 4'h8 >> i;
         @(posedge mclk);
         #1;
         ev = 4'h0;
         rd(8'h80, 16'h1 << pos[i]);
         rd(8'h80, 16'h1 << pos[i]);
         chk(alert_req, 1'b1);
         host_u.wr(8'h80, 8'hFF);
         rd(8'h80, 16'h0000);
      end
      // Masked sync fault: latched but silent
      alert_mask = 8'h02;
      ev = 4'h1;
      @(posedge mclk);
      #1;
      ev = 4'h0;
      chk(alert_req, 1'b0);
      rd(8'h80, 16'h0002);
      // Unmasked link fault beside it does alert
      ev = 4'h2;
      @(posedge mclk);
      #1;
      ev = 4'h0;
      chk(alert_req, 1'b1);
      host_u.clr();
      rd(8'h80, 16'h0000);
      chk(alert_req, 1'b0);
      // Event and clear-faults in one cycle: the event wins
      ev = 4'h1;
      host_u.clr();
      ev = 4'h0;
      rd(8'h80, 16'h0002);
      host_u.clr();
      rd(8'h80, 16'h0000);
      alert_mask = 8'hFF;
      busy = 1'b1;
      rd(8'h80, 16'h0040);
      busy = 1'b0;
      pend = 1'b1;
      rd(8'h80, 16'h0040);
      pend = 1'b0;
      rd(8'h80, 16'h0000);
      alert_mask = 8'h00;
      host_u.wr(8'h88, 8'h5A);
      @(posedge mclk);
      #1;
      chk(cml_ivc, 1'b1);
      chk(cml_fault, 1'b1);
      chk(alert_req, 1'b1);
      host_u.clr();
      @(posedge mclk);
      #1;
      chk(cml_ivc, 1'b0);
      host_u.wr(8'h8B, 8'hA5);
      chk(cml_ivc, 1'b1);
      host_u.clr();
      // First refresh lands about one refresh period after reset
      for (int n = 0; vin_rd !== mvin; n++)
      begin
         if (n > PST_REFRESH_CYC + 200)
         begin
            miscompares++;
            complete_run();
         end
         @(posedge mclk);
         #1;
      end
      rd(8'h88, mvin);
      rd(8'h8B, raw);
      complete_run();
   end
endmodule
